/* File: rtl/fobx_exec.sv */
// Purpose: Executes file ops and the absolute jump, one word per enable.
// Assumes: INSN_VALID marks one instruction cycle; FILE_RDATA is the
//          addressed register read combinationally for the word on INSN.
// Notes:   A flush cycle ignores INSN and acts as a no-operation.
`timescale 1ns/1ps
module fobx_exec #(
    parameter int INSN_W = 14,
    parameter int DATA_W = 8,
    parameter int ADDR_W = 7,
    parameter int PC_W   = 13
) (
    input  wire  logic              MCLK,
    input  wire  logic              SYS_RST,
    input  wire  logic              INSN_VALID,
    input  wire  logic [INSN_W-1:0] INSN,
    input  wire  logic [DATA_W-1:0] FILE_RDATA,
    input  wire  logic [DATA_W-1:0] PAGE_LATCH,
    input  wire  logic [PC_W-1:0]   PC_IN,
    output logic       [ADDR_W-1:0] FILE_ADDR,
    output logic       [DATA_W-1:0] FILE_WDATA,
    output logic                    FILE_WE,
    output logic       [DATA_W-1:0] WORK_REG,
    output logic                    ZERO_FLAG,
    output logic                    ZERO_WE,
    output logic       [PC_W-1:0]   PC_OUT,
    output logic                    PC_LOAD,
    output logic                    FLUSH,
    output logic                    BUSY
);

    // ********************************************************
    // Decode.
    // ********************************************************
    fobx_pkg::fobx_op_type    op;
    fobx_pkg::fobx_state_type state_r;
    logic [DATA_W-1:0]        result;
    logic                     is_zero;
    logic                     active;
    logic                     dest_file;

    assign active    = INSN_VALID && (state_r == fobx_pkg::FOBX_EXEC);
    assign dest_file = INSN[fobx_pkg::DEST_BIT];

    always_comb begin
        op = fobx_pkg::FOBX_NONE_OP;
        if (INSN[13:11] == fobx_pkg::OP_JUMP) begin
            op = fobx_pkg::FOBX_JUMP_OP;
        end else begin
            unique case (INSN[13:8])
                fobx_pkg::OP_COMPLEMENT: op = fobx_pkg::FOBX_COMP_OP;
                fobx_pkg::OP_DECREMENT:  op = fobx_pkg::FOBX_DEC_OP;
                fobx_pkg::OP_INCREMENT:  op = fobx_pkg::FOBX_INC_OP;
                fobx_pkg::OP_DEC_SKIP:   op = fobx_pkg::FOBX_DECSKIP_OP;
                fobx_pkg::OP_INC_SKIP:   op = fobx_pkg::FOBX_INCSKIP_OP;
                default:                 op = fobx_pkg::FOBX_NONE_OP;
            endcase
        end
    end

    fobx_alu #(
        .DATA_W (DATA_W)
    ) u_alu (
        .op      (op),
        .operand (FILE_RDATA),
        .result  (result),
        .is_zero (is_zero)
    );

    // ********************************************************
    // Sequencing.
    // ********************************************************
    logic is_file_op;
    logic is_skip;
    logic take_flush;

    assign is_file_op = (op != fobx_pkg::FOBX_NONE_OP) &&
                        (op != fobx_pkg::FOBX_JUMP_OP);
    assign is_skip    = (op == fobx_pkg::FOBX_DECSKIP_OP) ||
                        (op == fobx_pkg::FOBX_INCSKIP_OP);
    assign take_flush = (op == fobx_pkg::FOBX_JUMP_OP) ||
                        (is_skip && is_zero);

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            state_r <= fobx_pkg::FOBX_EXEC;
        end else if (INSN_VALID) begin
            unique case (state_r)
                fobx_pkg::FOBX_EXEC: begin
                    if (take_flush) begin
                        state_r <= fobx_pkg::FOBX_FLUSH;
                    end
                end
                fobx_pkg::FOBX_FLUSH: begin
                    state_r <= fobx_pkg::FOBX_EXEC;
                end
                default: begin
                    state_r <= fobx_pkg::FOBX_EXEC;
                end
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            FLUSH <= 1'b0;
            BUSY  <= 1'b0;
        end else begin
            FLUSH <= active && take_flush;
            BUSY  <= active ? take_flush : (BUSY && !INSN_VALID);
        end
    end

    // ********************************************************
    // File register, working register and zero flag writes.
    // ********************************************************
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            FILE_ADDR  <= '0;
            FILE_WDATA <= fobx_pkg::DATA_RST;
            FILE_WE    <= 1'b0;
        end else begin
            FILE_WE <= active && is_file_op && dest_file;
            if (active && is_file_op) begin
                FILE_ADDR  <= INSN[ADDR_W-1:0];
                FILE_WDATA <= result;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            WORK_REG <= fobx_pkg::DATA_RST;
        end else if (active && is_file_op && !dest_file) begin
            WORK_REG <= result;
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            ZERO_FLAG <= 1'b0;
            ZERO_WE   <= 1'b0;
        end else begin
            ZERO_WE <= active && is_file_op && !is_skip;
            if (active && is_file_op && !is_skip) begin
                ZERO_FLAG <= is_zero;
            end
        end
    end

    // ********************************************************
    // Program counter.
    // ********************************************************
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            PC_OUT  <= fobx_pkg::PC_RST;
            PC_LOAD <= 1'b0;
        end else begin
            PC_LOAD <= active && (op == fobx_pkg::FOBX_JUMP_OP);
            if (active && (op == fobx_pkg::FOBX_JUMP_OP)) begin
                PC_OUT <= {PAGE_LATCH[fobx_pkg::PAGE_HI:fobx_pkg::PAGE_LO],
                           INSN[fobx_pkg::LIT_W-1:0]};
            end else if (active) begin
                PC_OUT <= PC_IN + 1'b1;
            end
        end
    end

endmodule

/* File: rtl/fobx_pkg.sv */
// Purpose: Constants and types for the file operation and branch executor.
// Assumes: 14-bit instruction words, 8-bit data, 13-bit program counter.
// Notes:   File op opcode fields sit in instruction bits 13:8; the jump opcode sits in bits 13:11.
package fobx_pkg;

    localparam int INSN_W      = 14;
    localparam int DATA_W      = 8;
    localparam int ADDR_W      = 7;
    localparam int PC_W        = 13;
    localparam int LIT_W       = 11;

    localparam logic [5:0] OP_COMPLEMENT = 6'h09;
    localparam logic [5:0] OP_DECREMENT  = 6'h03;
    localparam logic [5:0] OP_INCREMENT  = 6'h0A;
    localparam logic [5:0] OP_DEC_SKIP   = 6'h0B;
    localparam logic [5:0] OP_INC_SKIP   = 6'h0F;
    localparam logic [2:0] OP_JUMP       = 3'h5;

    localparam int DEST_BIT    = 7;
    localparam int PAGE_LO     = 3;
    localparam int PAGE_HI     = 4;
    localparam int ZERO_BIT    = 2;

    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    localparam logic [PC_W-1:0]   PC_RST   = 13'h0000;

    typedef enum logic [2:0] {
        FOBX_NONE_OP,
        FOBX_COMP_OP,
        FOBX_DEC_OP,
        FOBX_INC_OP,
        FOBX_DECSKIP_OP,
        FOBX_INCSKIP_OP,
        FOBX_JUMP_OP
    } fobx_op_type;

    typedef enum logic [1:0] {
        FOBX_EXEC,
        FOBX_FLUSH
    } fobx_state_type;

endpackage

/* File: rtl/fobx_alu.sv */
// Purpose: Combinational data path for the file register operations.
// Assumes: Operand is the addressed file register contents.
// Notes:   The zero result flag is computed for every operation, raised only when the result is zero.
`timescale 1ns/1ps
module fobx_alu #(
    parameter int DATA_W = 8
) (
    input  wire fobx_pkg::fobx_op_type op,
    input  wire logic [DATA_W-1:0]     operand,
    output logic      [DATA_W-1:0]     result,
    output logic                       is_zero
);

    always_comb begin
        unique case (op)
            fobx_pkg::FOBX_COMP_OP:    result = ~operand;
            fobx_pkg::FOBX_DEC_OP,
            fobx_pkg::FOBX_DECSKIP_OP: result = operand - 1'b1;
            fobx_pkg::FOBX_INC_OP,
            fobx_pkg::FOBX_INCSKIP_OP: result = operand + 1'b1;
            default:                   result = operand;
        endcase
        is_zero = (result == '0);
    end

endmodule

/* File: tb/fobx_exec_assertions.sv */
// Purpose: Port checks for the file operation and branch executor.
// Assumes: Outputs follow a taken word by exactly one cycle.
// Notes:   A word is taken when INSN_VALID is high outside a flush.
`timescale 1ns/1ps
module fobx_exec_chk (
    input wire logic        MCLK,
    input wire logic        SYS_RST,
    input wire logic        INSN_VALID,
    input wire logic [13:0] INSN,
    input wire logic [7:0]  FILE_RDATA,
    input wire logic [7:0]  PAGE_LATCH,
    input wire logic [7:0]  FILE_WDATA,
    input wire logic        FILE_WE,
    input wire logic [7:0]  WORK_REG,
    input wire logic        ZERO_FLAG,
    input wire logic        ZERO_WE,
    input wire logic [12:0] PC_OUT,
    input wire logic        PC_LOAD,
    input wire logic        FLUSH,
    input wire logic        BUSY
);
    // ********************************
    // Helpers and properties.
    // ********************************
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (SYS_RST);
    wire         tk = INSN_VALID && !BUSY;
    wire [5:0]   op = INSN[13:8];
    wire         jp = INSN[13:11] == 3'h5;
    wire         sk = op == 6'h0B || op == 6'h0F;
    wire         sz = op == 6'h0B ? FILE_RDATA == 8'h01 : FILE_RDATA == 8'hFF;
    logic [12:0] jt_r;
    logic [7:0]  rd_r;
    always_ff @(posedge MCLK) begin
        jt_r <= {PAGE_LATCH[4:3], INSN[10:0]};
        rd_r <= FILE_RDATA;
    end
    sequence s_drop;
        FLUSH && BUSY && !ZERO_WE ##1 !ZERO_WE && !FILE_WE && !PC_LOAD;
    endsequence
    chk_comp_inv: assert property (tk && op == 6'h09 && INSN[7] |=>
        FILE_WE && FILE_WDATA == ~rd_r) else $error("complement wrong");
    chk_dest_work: assert property (tk && op == 6'h03 && !INSN[7] |=>
        !FILE_WE && WORK_REG == rd_r - 8'h01) else $error("work dest wrong");
    chk_jump_pc: assert property (tk && jp |=> PC_LOAD && PC_OUT == jt_r)
        else $error("jump target wrong");
    chk_jump_hold: assert property (tk && jp |=> s_drop)
        else $error("jump cycle wrong");
    chk_dec_zero: assert property (tk && op == 6'h03 |=> ZERO_WE &&
        ZERO_FLAG == (rd_r == 8'h01)) else $error("decrement zero wrong");
    chk_inc_zero: assert property (tk && op == 6'h0A |=> ZERO_WE &&
        ZERO_FLAG == (rd_r == 8'hFF)) else $error("increment zero wrong");
    chk_skip_zero: assert property (tk && sk && sz |=> s_drop)
        else $error("zero skip wrong");
    chk_skip_pass: assert property (tk && sk && !sz |=>
        !FLUSH && !BUSY && !ZERO_WE) else $error("nonzero skip wrong");
endmodule
bind fobx_exec fobx_exec_chk u_chk (.MCLK(MCLK), .SYS_RST(SYS_RST),
    .INSN_VALID(INSN_VALID), .INSN(INSN), .FILE_RDATA(FILE_RDATA),
    .PAGE_LATCH(PAGE_LATCH), .FILE_WDATA(FILE_WDATA), .FILE_WE(FILE_WE),
    .WORK_REG(WORK_REG), .ZERO_FLAG(ZERO_FLAG), .ZERO_WE(ZERO_WE),
    .PC_OUT(PC_OUT), .PC_LOAD(PC_LOAD), .FLUSH(FLUSH), .BUSY(BUSY));

/* File: tb/file_op_and_branch_exec_tb.sv */
// Purpose: Self-checking bench for the file operation and branch executor.
// Assumes: Inputs change on the falling edge of the clock.
// Notes:   Words are issued back to back.
`timescale 1ns/1ps
module file_op_and_branch_exec_tb;
    // ********************************
    // Stimulus and scenarios.
    // ********************************
    logic        mclk = 1'b0, sys_rst = 1'b1, iv = 1'b0;
    logic [13:0] insn = 14'h0000;
    logic [7:0]  rdata = 8'h00, page = 8'h00, wdata, wreg;
    logic [12:0] pc_in = 13'h0000, pc_out;
    logic [6:0]  faddr;
    logic        fwe, zf, zwe, pcl, flush, busy;
    int          miscompares = 0, n_compared = 0, cycles = 0;
    fobx_exec dut (.MCLK(mclk), .SYS_RST(sys_rst), .INSN_VALID(iv),
        .INSN(insn), .FILE_RDATA(rdata), .PAGE_LATCH(page), .PC_IN(pc_in),
        .FILE_ADDR(faddr), .FILE_WDATA(wdata), .FILE_WE(fwe), .WORK_REG(wreg),
        .ZERO_FLAG(zf), .ZERO_WE(zwe), .PC_OUT(pc_out), .PC_LOAD(pcl),
        .FLUSH(flush), .BUSY(busy));
    always #5 mclk = ~mclk;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic put(input logic [13:0] w, input logic [7:0] rd);
        iv = 1'b1;
        insn = w;
        rdata = rd;
        pc_in = pc_in + 13'h0001;
        @(negedge mclk);
    endtask
    task automatic t_file();
        logic [5:0] ops [3] = '{6'h09, 6'h03, 6'h0A};
        logic [7:0] v [3] = '{8'h00, 8'h01, 8'hFF};
        logic [7:0] e;
        for (int i = 0; i < 3; i++) begin
            for (int j = 0; j < 6; j++) begin
                put({ops[i], j[0], 7'(j + 120)}, v[j / 2]);
                e = i == 0 ? ~v[j / 2] : v[j / 2] + (i == 1 ? 8'hFF : 8'h01);
                chk({fwe, j[0] ? {faddr, wdata} : {7'h00, wreg}},
                    {j[0], j[0] ? 7'(j + 120) : 7'h00, e});
                chk({zwe, zf}, {1'b1, e == 8'h00});
                chk({busy, flush, pc_out}, {2'b00, pc_in + 13'h0001});
            end
        end
    endtask
    task automatic t_skip();
        logic [7:0] rd;
        for (int i = 0; i < 4; i++) begin
            rd = i[1] ? 8'h05 : (i[0] ? 8'hFF : 8'h01);
            put({i[0] ? 6'h0F : 6'h0B, 1'b1, 7'h10}, rd);
            chk({flush, zwe}, {!i[1], 1'b0});
            chk(wdata, 8'(i[0] ? rd + 8'h01 : rd - 8'h01));
            put({6'h0A, 1'b1, 7'h11}, 8'h22);
            chk(fwe, i[1]);
        end
    endtask
    task automatic t_jump();
        logic [7:0]  pl [2] = '{8'hE7, 8'h18};
        logic [10:0] k [2] = '{11'h7FF, 11'h123};
        logic        z;
        for (int i = 0; i < 2; i++) begin
            page = pl[i];
            z = zf;
            put({3'h5, k[i]}, 8'h00);
            chk({pcl, flush, busy, pc_out}, {3'b111, pl[i][4:3], k[i]});
            chk({zwe, zf}, {1'b0, z});
            put({6'h09, 1'b1, 7'h12}, 8'h00);
            chk({fwe, zwe, pcl, busy}, 4'h0);
            chk(pc_out, {pl[i][4:3], k[i]});
        end
        put(14'h0000, 8'h33);
        chk({fwe, zwe, pcl, flush, busy}, 5'h00);
        chk(pc_out, pc_in + 13'h0001);
    endtask
    task automatic end_sim();
        $display("Compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 1000) begin
            miscompares++;
            end_sim();
        end
    end
    initial begin
        repeat (20) @(negedge mclk);
        sys_rst = 1'b0;
        t_file();
        t_skip();
        t_jump();
        end_sim();
    end
endmodule
